// ==== wdr_pkg.sv ====
// Constants shared by the watchdog supervision block: register map,
// field positions, unlock keys and cycle counts.
// Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus.

package wdr_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses.
  // ----------------------------------------------------------------------
  localparam logic [11:0] WDR_ADDR_WDCTL   = 12'h0D8; // watchdog_control
  localparam logic [11:0] WDR_ADDR_XIE     = 12'h0E8; // ext. int. enable
  localparam logic [11:0] WDR_ADDR_XIP     = 12'h0F8; // ext. int. priority
  localparam logic [11:0] WDR_ADDR_UNLOCK  = 12'h100; // timed_access_unlock
  localparam logic [11:0] WDR_ADDR_TOSEL   = 12'h104; // timeout length
  localparam logic [11:0] WDR_ADDR_ISTAT   = 12'h108; // event status, RO
  localparam logic [11:0] WDR_ADDR_ICLR    = 12'h10C; // event clear, WO
  localparam logic [11:0] WDR_ADDR_IEN     = 12'h110; // event enable

  // ----------------------------------------------------------------------
  // Field positions of watchdog_control.
  // ----------------------------------------------------------------------
  localparam int WDR_B_BAUD   = 7; // second_port_baud_doubler
  localparam int WDR_B_PWRUP  = 6; // power-up flag
  localparam int WDR_B_WIF    = 3; // watchdog_interrupt_flag
  localparam int WDR_B_CAUSE  = 2; // watchdog_reset_cause_flag
  localparam int WDR_B_RSTEN  = 1; // watchdog_reset_enable
  localparam int WDR_B_RESTRT = 0; // watchdog_restart

  // Field position of the watchdog bit in the enable/priority registers.
  localparam int WDR_B_XWD    = 4;

  // Upper reserved bits of the extended enable register read high.
  localparam logic [2:0] WDR_XIE_RSVD = 3'h7;

  // Event bits of the status, clear and enable registers.
  localparam int WDR_EV_TIMEOUT = 0;
  localparam int WDR_EV_WDRST   = 1;
  localparam int WDR_EV_W       = 2;

  // ----------------------------------------------------------------------
  // Unlock sequence and timing.
  // ----------------------------------------------------------------------
  localparam logic [7:0] WDR_UNLOCK_KEY1 = 8'hAA;
  localparam logic [7:0] WDR_UNLOCK_KEY2 = 8'h55;
  localparam int WDR_CLK_PER_MC    = 4;  // clocks per machine cycle
  localparam int WDR_UNLOCK_MC     = 3;  // open window, machine cycles
  localparam int WDR_UNLOCK_CYC    = WDR_UNLOCK_MC * WDR_CLK_PER_MC;
  localparam int WDR_RST_DLY_CLK   = 512; // timeout to reset, in clocks
  localparam int WDR_RST_DLY_CYC   = WDR_RST_DLY_CLK;
  localparam int WDR_EXP_STEP      = 3;  // timeout exponent step per sel

  // AXI responses.
  localparam logic [1:0] WDR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] WDR_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {WDR_UL_IDLE, WDR_UL_ARMED, WDR_UL_OPEN}
    wdr_ul_t;
  typedef enum logic {WDR_WD_COUNT, WDR_WD_DELAY} wdr_wd_t;

endpackage

// ==== wdr_top.sv ====
// Watchdog supervision block: control register, timed-access unlock,
// timeout counter with delayed reset, interrupt routing and an
// AXI4-Lite slave for software.
// Assumes aresetn is the power-on reset; external and power-fail resets
// arrive as asynchronous active-low pins and are synchronised here.
//
// Operation
// R01: Power-up flag set at power-on; only a software write clears it.
// R02: Timeout sets interrupt flag (interrupt or elapsed); software clears.
// R03: Watchdog reset sets the reset-cause flag; software clears it.
// R04: Power-fail, power-on or power-down reset clears the reset-cause flag.
// R05: With reset enable at 0 the watchdog never touches the cause flag.
// R06: Reset enable at 1 arms the watchdog reset; at 0 none occurs.
// R07: Writing restart clears the counter; the restart bit then self-clears.
// R08: Timeout raises interrupt; if reset enabled, reset 512 clocks later.
// R09: External reset loads control with 0x0x0xx0, x bits kept.
// R10: Cause flag set by watchdog reset, unchanged by external reset.
// R11: Power-on sets power-up flag, clears reset enable; others keep it.
// R12: All bits readable; protected bits written only inside unlock window.
// R13: Baud doubler bit doubles second port rate in modes 1 to 3.
// R14: Watchdog interrupt passes only when enable bit 4 is set.
// R15: A priority bit selects the watchdog interrupt service level.
// R16: Three upper bits of the enable register read as 1.
// R17: Unlock is AAh then 55h next write; opens three machine cycles.
// R18: Priority bit 1 means high priority, 0 means low.
// R19: Counter runs on core clock; length chosen by a select register.
//
// Our own choice: register access over AXI4-Lite.

`timescale 1ns/10ps

module wdr_top
  import wdr_pkg::*;
#(
  parameter int WDT_EXP0 = 17 // log2 of the shortest timeout in clocks
)(
  input  wire logic        aclk,           // Core clock, 100 MHz.
  input  wire logic        aresetn,        // Power-on reset, active low.
  input  wire logic        ext_rst_n,      // External reset pin.
  input  wire logic        pwr_fail_n,     // Power-fail/down reset pin.
  input  wire logic [11:0] s_axi_awaddr,   // Write address.
  input  wire logic        s_axi_awvalid,  // Write address valid.
  output logic             s_axi_awready,  // Write address ready.
  input  wire logic [31:0] s_axi_wdata,    // Write data.
  input  wire logic [3:0]  s_axi_wstrb,    // Write byte enables.
  input  wire logic        s_axi_wvalid,   // Write data valid.
  output logic             s_axi_wready,   // Write data ready.
  output logic [1:0]       s_axi_bresp,    // Write response.
  output logic             s_axi_bvalid,   // Write response valid.
  input  wire logic        s_axi_bready,   // Write response ready.
  input  wire logic [11:0] s_axi_araddr,   // Read address.
  input  wire logic        s_axi_arvalid,  // Read address valid.
  output logic             s_axi_arready,  // Read address ready.
  output logic [31:0]      s_axi_rdata,    // Read data.
  output logic [1:0]       s_axi_rresp,    // Read response.
  output logic             s_axi_rvalid,   // Read data valid.
  input  wire logic        s_axi_rready,   // Read data ready.
  output logic             wd_irq_req,     // Watchdog request to int. ctrl.
  output logic             wd_irq_high,    // Request is high priority.
  output logic             wd_reset_out,   // Watchdog reset pulse.
  output logic             baud_double,    // Second port baud doubler.
  output logic             irq             // Block event interrupt.
);

  import wdr_pkg::*;

  localparam int CNT_W = WDT_EXP0 + 3 * WDR_EXP_STEP;

  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  logic [1:0]        ext_sync_q;
  logic [1:0]        pf_sync_q;
  logic              ext_rst;
  logic              pf_rst;
  logic              aw_full_q;
  logic              w_full_q;
  logic [11:0]       wr_addr_q;
  logic [7:0]        wr_data_q;
  logic              wr_lane_q;
  logic              wr_go;
  logic              wr_b0;
  logic              map_hit;
  wdr_ul_t           ul_st_q;
  logic [4:0]        ul_cnt_q;
  logic              ul_open;
  logic              baud_q;
  logic              pwrup_q;
  logic              wif_q;
  logic              cause_q;
  logic              rsten_q;
  logic              restrt_q;
  logic [3:0]        xie_q;
  logic              xwd_en_q;
  logic [3:0]        xip_q;
  logic              xwd_pr_q;
  logic [1:0]        tosel_q;
  wdr_wd_t           wd_st_q;
  logic [CNT_W-1:0]  wd_cnt_q;
  logic [9:0]        dly_q;
  logic              wd_restart;
  logic              to_ev;
  logic              wd_fire;
  logic              wd_rst_q;
  logic [WDR_EV_W-1:0] ist_q;
  logic [WDR_EV_W-1:0] ien_q;
  logic [WDR_EV_W-1:0] ev_set;

  // ----------------------------------------------------------------------
  // Helper functions.
  // ----------------------------------------------------------------------

  // Terminal count for a timeout selection: 2^(exp0 + 3*sel) - 1.
  function automatic logic [CNT_W-1:0] wdr_limit(input logic [1:0] sel);
    logic [CNT_W:0] one;
    one = '0;
    one[WDT_EXP0 + WDR_EXP_STEP * int'(sel)] = 1'b1;
    return CNT_W'(one - 1'b1);
  endfunction

  // True when the address names one of this block's registers.
  function automatic logic wdr_mapped(input logic [11:0] a);
    return (a == WDR_ADDR_WDCTL)  || (a == WDR_ADDR_XIE)  ||
           (a == WDR_ADDR_XIP)    || (a == WDR_ADDR_UNLOCK) ||
           (a == WDR_ADDR_TOSEL)  || (a == WDR_ADDR_ISTAT) ||
           (a == WDR_ADDR_ICLR)   || (a == WDR_ADDR_IEN);
  endfunction

  // ----------------------------------------------------------------------
  // Reset pin synchronisers.
  // ----------------------------------------------------------------------

  // Both pins are asynchronous; only the second stage is used.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_sync_q <= 2'h3;
      pf_sync_q  <= 2'h3;
    end
    else
    begin
      ext_sync_q <= {ext_sync_q[0], ext_rst_n};
      pf_sync_q  <= {pf_sync_q[0], pwr_fail_n};
    end
  end

  assign ext_rst = ~ext_sync_q[1];
  assign pf_rst  = ~pf_sync_q[1];

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel.
  // ----------------------------------------------------------------------

  // Address and data are caught independently; the write commits once
  // both are held and no response is outstanding.
  assign wr_go   = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_b0   = wr_go & wr_lane_q;
  assign map_hit = wdr_mapped(wr_addr_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q     <= 1'b0;
      s_axi_awready <= 1'b1;
      wr_addr_q     <= 12'h000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_q     <= 1'b1;
      s_axi_awready <= 1'b0;
      wr_addr_q     <= s_axi_awaddr;
    end
    else if (wr_go)
    begin
      aw_full_q     <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // Only byte lane 0 carries register data; other lanes are ignored.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_q     <= 1'b0;
      s_axi_wready <= 1'b1;
      wr_data_q    <= 8'h00;
      wr_lane_q    <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_q     <= 1'b1;
      s_axi_wready <= 1'b0;
      wr_data_q    <= s_axi_wdata[7:0];
      wr_lane_q    <= s_axi_wstrb[0];
    end
    else if (wr_go)
    begin
      w_full_q     <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // Write response: unmapped addresses answer with a slave error.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= WDR_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= map_hit ? WDR_RESP_OKAY : WDR_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel.
  // ----------------------------------------------------------------------

  // Reads have no side effects, so data is sampled at the address edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= WDR_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= wdr_mapped(s_axi_araddr) ? WDR_RESP_OKAY
                                                : WDR_RESP_SLVERR;
      case (s_axi_araddr)
        WDR_ADDR_WDCTL:                                              // R12
          s_axi_rdata <= {24'h000000, baud_q, pwrup_q, 2'b00, wif_q,
                          cause_q, rsten_q, restrt_q};
        WDR_ADDR_XIE:
          s_axi_rdata <= {24'h000000, WDR_XIE_RSVD, xwd_en_q, xie_q}; // R16
        WDR_ADDR_XIP:
          s_axi_rdata <= {24'h000000, 3'b000, xwd_pr_q, xip_q};
        WDR_ADDR_TOSEL:
          s_axi_rdata <= {30'h00000000, tosel_q};
        WDR_ADDR_ISTAT:
          s_axi_rdata <= {30'h00000000, ist_q};
        WDR_ADDR_IEN:
          s_axi_rdata <= {30'h00000000, ien_q};
        default:
          s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Timed-access unlock.
  // ----------------------------------------------------------------------

  // Any write in between the two keys, other than AAh again to the unlock register, breaks the
  // sequence; this keeps a runaway program from opening the window.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ul_st_q  <= WDR_UL_IDLE;
      ul_cnt_q <= 5'h00;
    end
    else
    begin
      case (ul_st_q)
        WDR_UL_IDLE:
        begin
          if (wr_b0 && wr_addr_q == WDR_ADDR_UNLOCK &&
              wr_data_q == WDR_UNLOCK_KEY1)
            ul_st_q <= WDR_UL_ARMED;                                 // R17
        end
        WDR_UL_ARMED:
        begin
          if (wr_go)
          begin
            if (wr_lane_q && wr_addr_q == WDR_ADDR_UNLOCK &&
                wr_data_q == WDR_UNLOCK_KEY2)
            begin
              ul_st_q  <= WDR_UL_OPEN;                               // R17
              ul_cnt_q <= 5'(WDR_UNLOCK_CYC - 1);
            end
            else if (wr_lane_q && wr_addr_q == WDR_ADDR_UNLOCK &&
                     wr_data_q == WDR_UNLOCK_KEY1)
              ul_st_q <= WDR_UL_ARMED;
            else
              ul_st_q <= WDR_UL_IDLE;
          end
        end
        WDR_UL_OPEN:
        begin
          if (ul_cnt_q == 5'h00)
            ul_st_q <= WDR_UL_IDLE;                                  // R17
          else
            ul_cnt_q <= ul_cnt_q - 5'h01;
        end
        default:
          ul_st_q <= WDR_UL_IDLE;
      endcase
    end
  end

  assign ul_open = (ul_st_q == WDR_UL_OPEN);

  // ----------------------------------------------------------------------
  // Watchdog control register.
  // ----------------------------------------------------------------------

  // Hardware sets win over a software clear in the same cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      baud_q   <= 1'b0;
      pwrup_q  <= 1'b1;                                              // R01 R11
      wif_q    <= 1'b0;
      cause_q  <= 1'b0;                                              // R04
      rsten_q  <= 1'b0;                                              // R11
      restrt_q <= 1'b0;
    end
    else if (ext_rst || wd_rst_q)
    begin
      // Power-up flag and reset enable are kept; the cause flag changes only as below.
      baud_q   <= 1'b0;                                              // R09
      wif_q    <= 1'b0;                                              // R09
      restrt_q <= 1'b0;                                              // R09
      if (wd_rst_q)
        cause_q <= 1'b1;                                             // R03 R10
      if (pf_rst)
        cause_q <= 1'b0;                                             // R04
    end
    else
    begin
      restrt_q <= 1'b0;                                              // R07
      if (wr_b0 && wr_addr_q == WDR_ADDR_WDCTL)
      begin
        baud_q <= wr_data_q[WDR_B_BAUD];                             // R12
        cause_q <= wr_data_q[WDR_B_CAUSE];                           // R03
        if (ul_open)
        begin
          pwrup_q  <= wr_data_q[WDR_B_PWRUP];                        // R01 R12
          rsten_q  <= wr_data_q[WDR_B_RSTEN];                        // R06 R12
          wif_q    <= wr_data_q[WDR_B_WIF];                          // R02 R12
          restrt_q <= wr_data_q[WDR_B_RESTRT];                       // R07 R12
        end
      end
      if (to_ev)
        wif_q <= 1'b1;                                               // R02
      if (pf_rst)
        cause_q <= 1'b0;                                             // R04
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt enable, priority and timeout select registers.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      xie_q    <= 4'h0;
      xwd_en_q <= 1'b0;
      xip_q    <= 4'h0;
      xwd_pr_q <= 1'b0;
      tosel_q  <= 2'h0;
    end
    else if (wr_b0)
    begin
      case (wr_addr_q)
        WDR_ADDR_XIE:
        begin
          xie_q    <= wr_data_q[3:0];
          xwd_en_q <= wr_data_q[WDR_B_XWD];                          // R14
        end
        WDR_ADDR_XIP:
        begin
          xip_q    <= wr_data_q[3:0];
          xwd_pr_q <= wr_data_q[WDR_B_XWD];                          // R15
        end
        WDR_ADDR_TOSEL:
          tosel_q <= wr_data_q[1:0];                                 // R19
        default:
          tosel_q <= tosel_q;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog counter and delayed reset.
  // ----------------------------------------------------------------------

  // The counter is free-running even with resets disabled, so that the
  // interrupt flag still reports an elapsed timeout.
  assign wd_restart = restrt_q | ext_rst | wd_rst_q;
  assign to_ev      = (wd_st_q == WDR_WD_COUNT) & ~wd_restart &
                      (wd_cnt_q == wdr_limit(tosel_q));
  assign wd_fire    = (wd_st_q == WDR_WD_DELAY) & ~wd_restart & rsten_q &
                      (dly_q == 10'(WDR_RST_DLY_CYC - 1));           // R05 R06

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wd_st_q  <= WDR_WD_COUNT;
      wd_cnt_q <= '0;
      dly_q    <= 10'h000;
    end
    else if (wd_restart)
    begin
      wd_st_q  <= WDR_WD_COUNT;                                      // R07
      wd_cnt_q <= '0;
      dly_q    <= 10'h000;
    end
    else
    begin
      case (wd_st_q)
        WDR_WD_COUNT:
        begin
          if (to_ev)
          begin
            wd_st_q <= WDR_WD_DELAY;                                 // R08
            dly_q   <= 10'h000;
          end
          else
            wd_cnt_q <= wd_cnt_q + 1'b1;                             // R19
        end
        WDR_WD_DELAY:
        begin
          if (dly_q == 10'(WDR_RST_DLY_CYC - 1))
          begin
            wd_st_q  <= WDR_WD_COUNT;                                // R08
            wd_cnt_q <= '0;
          end
          else
            dly_q <= dly_q + 10'h001;
        end
        default:
          wd_st_q <= WDR_WD_COUNT;
      endcase
    end
  end

  // One-cycle reset pulse, also fed back to reinitialise the block.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wd_rst_q <= 1'b0;
    else
      wd_rst_q <= wd_fire;                                           // R06 R08
  end

  // ----------------------------------------------------------------------
  // Event status and interrupt outputs.
  // ----------------------------------------------------------------------
  assign ev_set = {wd_fire, to_ev};

  // Status bits are sticky; a clear write loses to a same-cycle event.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ist_q <= '0;
      ien_q <= '0;
    end
    else
    begin
      if (wr_b0 && wr_addr_q == WDR_ADDR_ICLR)
        ist_q <= (ist_q & ~wr_data_q[WDR_EV_W-1:0]) | ev_set;
      else
        ist_q <= ist_q | ev_set;
      if (wr_b0 && wr_addr_q == WDR_ADDR_IEN)
        ien_q <= wr_data_q[WDR_EV_W-1:0];
    end
  end

  // All outputs are registered.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wd_irq_req   <= 1'b0;
      wd_irq_high  <= 1'b0;
      wd_reset_out <= 1'b0;
      baud_double  <= 1'b0;
      irq          <= 1'b0;
    end
    else
    begin
      wd_irq_req   <= wif_q & xwd_en_q;                              // R02 R14
      wd_irq_high  <= xwd_pr_q;                                      // R15 R18
      wd_reset_out <= wd_fire;                                       // R08
      baud_double  <= baud_q;                                        // R13
      irq          <= |(ist_q & ien_q);
    end
  end

endmodule // wdr_top

// ==== wdr_top_assertions.sv ====
// Port-level checks for the watchdog block, attached by bind.
// Assumes one clock domain with a synchronous active-low aresetn.
`timescale 1ns/10ps

module wdr_top_assertions (
  input wire logic        aclk,          // Core clock.
  input wire logic        aresetn,       // Power-on reset.
  input wire logic        s_axi_awvalid, // Write address valid.
  input wire logic        s_axi_awready, // Write address ready.
  input wire logic        s_axi_wvalid,  // Write data valid.
  input wire logic        s_axi_wready,  // Write data ready.
  input wire logic        s_axi_bvalid,  // Write response valid.
  input wire logic        s_axi_bready,  // Write response ready.
  input wire logic        s_axi_arvalid, // Read address valid.
  input wire logic        s_axi_arready, // Read address ready.
  input wire logic        s_axi_rvalid,  // Read data valid.
  input wire logic        s_axi_rready,  // Read data ready.
  input wire logic [31:0] s_axi_rdata,   // Read data.
  input wire logic        wd_reset_out   // Watchdog reset pulse.
);
  // All checks share the core clock; reset silences them.
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_rst_pulse; wd_reset_out |=> !wd_reset_out; endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("reset pulse too long");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("bvalid dropped early");
  property p_aw_b; s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_aw_b: assert property (p_aw_b)
    else $error("write answer late");
  property p_aw_lock; s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_lock: assert property (p_aw_lock)
    else $error("awready not dropped");
  property p_b_free; s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready; endproperty
  a_b_free: assert property (p_b_free)
    else $error("write not released");
  // Byte registers: the upper read lanes are always zero.
  property p_r_data; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_r_data: assert property (p_r_data)
    else $error("read upper lanes set");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_ar_r; s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready; endproperty
  a_ar_r: assert property (p_ar_r)
    else $error("read answer late");
endmodule // wdr_top_assertions

bind wdr_top wdr_top_assertions wdr_top_assertions_inst (.*);

// ==== test_watchdog_reset_control.sv ====
// Self-checking bench for the watchdog block over AXI4-Lite.
// Assumes a short timeout parameter so the timed timeout, at select 1, takes 128 cycles.
`timescale 1ns/10ps

module test_watchdog_reset_control;
  import wdr_pkg::*;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ext_rst_n = 1'b1;
  logic        pwr_fail_n = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0;
  logic [11:0] s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, wd_irq_req, wd_irq_high, wd_reset_out;
  logic        baud_double, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, wr_resp;
  logic [31:0] s_axi_rdata;
  int          failures = 0;
  int          n_compared = 0;

  // A small exponent keeps the run short: 2^(4+3) = 128 cycles.
  wdr_top #(.WDT_EXP0(4)) wdr_top_inst (.*);

  // Free-running core clock.
  always #5 aclk = ~aclk;

  task automatic finish_test;
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic expire;
    failures++;
    finish_test();
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // Handshakes are sampled at the falling edge, acted on at the rising.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [2:0] h;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    h = 3'h0;
    for (int n = 0; n < 40 && !h[2]; n++)
    begin
      @(negedge aclk);
      h[0] = s_axi_awvalid & s_axi_awready;
      h[1] = s_axi_wvalid & s_axi_wready;
      h[2] = s_axi_bvalid;
      wr_resp = s_axi_bresp;
      @(posedge aclk);
      if (h[0]) s_axi_awvalid <= 1'b0;
      if (h[1]) s_axi_wvalid <= 1'b0;
      if (h[2]) s_axi_bready <= 1'b0;
    end
    if (!h[2]) expire();
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic k, g;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    g = 1'b0;
    for (int n = 0; n < 40 && !g; n++)
    begin
      @(negedge aclk);
      k = s_axi_arvalid & s_axi_arready;
      g = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (k) s_axi_arvalid <= 1'b0;
      if (g) s_axi_rready <= 1'b0;
    end
    if (!g) expire();
    @(posedge aclk);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, e, d);
  endtask

  // Reset values, reserved bits, and an unmapped read.
  task automatic s_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rdchk("ctl", WDR_ADDR_WDCTL, 32'h40);
    wr(WDR_ADDR_TOSEL, 8'h03);
    rdchk("xie", WDR_ADDR_XIE, 32'hE0);
    rd(12'h0FC, d, r);
    chk("resp", {30'h0, WDR_RESP_SLVERR}, {30'h0, r});
    wr(12'h0FC, 8'h00);
    chk("bresp", 32'(WDR_RESP_SLVERR), 32'(wr_resp));
  endtask

  // Without unlock only the free bits take the write.
  task automatic s_protect;
    wr(WDR_ADDR_WDCTL, 8'h82);
    rdchk("ctl", WDR_ADDR_WDCTL, 32'hC0);
    chk("baud", 32'h1, 32'(baud_double));
  endtask

  // Restart and arm, then time the delay from request to reset.
  task automatic s_timeout;
    int c;
    wr(WDR_ADDR_TOSEL, 8'h01);
    wr(WDR_ADDR_XIE, 8'h10);
    wr(WDR_ADDR_XIP, 8'h10);
    wr(WDR_ADDR_IEN, 8'h03);
    chk("prio", 32'h1, 32'(wd_irq_high));
    wr(WDR_ADDR_UNLOCK, WDR_UNLOCK_KEY1);
    wr(WDR_ADDR_UNLOCK, WDR_UNLOCK_KEY2);
    wr(WDR_ADDR_WDCTL, 8'hC3);
    c = 0;
    for (int n = 0; n < 900 && wd_reset_out !== 1'b1; n++)
    begin
      @(negedge aclk);
      c += int'(wd_irq_req === 1'b1);
    end
    if (wd_reset_out !== 1'b1) expire();
    chk("delay", 32'h200, 32'(c));
    @(posedge aclk);
    rdchk("ctl", WDR_ADDR_WDCTL, 32'h46);
    rdchk("st", WDR_ADDR_ISTAT, 32'h3);
    chk("irq", 32'h1, 32'(irq));
    wr(WDR_ADDR_IEN, 8'h00);
    @(negedge aclk);
    chk("irq", 32'h0, 32'(irq));
    @(posedge aclk);
    wr(WDR_ADDR_ICLR, 8'h03);
    rdchk("st", WDR_ADDR_ISTAT, 32'h0);
  endtask

  // External reset keeps bits 6,2,1; power-fail clears the cause flag.
  task automatic s_resets;
    wr(WDR_ADDR_WDCTL, 8'hC6);
    ext_rst_n <= 1'b0;
    repeat (6) @(posedge aclk);
    ext_rst_n <= 1'b1;
    repeat (4) @(posedge aclk);
    rdchk("ctl", WDR_ADDR_WDCTL, 32'h46);
    pwr_fail_n <= 1'b0;
    repeat (6) @(posedge aclk);
    pwr_fail_n <= 1'b1;
    repeat (4) @(posedge aclk);
    rdchk("ctl", WDR_ADDR_WDCTL, 32'h42);
  endtask

  // Main sequence: reset for eight cycles, then each scenario.
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    s_reset();
    s_protect();
    s_timeout();
    s_resets();
    finish_test();
  end
endmodule // test_watchdog_reset_control
